//--- core/wdt_defines.vh
// Purpose: Constants for the watchdog wake and reset timer.
// Assumes: 125 MHz system clock, 32-bit AXI4-Lite register access.
// Notes: Offsets are full byte addresses.
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

`define WDT_ADDR_W 32
`define WDT_STATUS_ADDR 32'hFFF7FD94
`define WDT_CONTROL_ADDR 32'hFFF7FD98
`define WDT_MASK_ADDR 32'hFFF7FD9C

// Status bits.
`define WDT_ST_HALF_RAW 3
`define WDT_ST_TERM_RAW 2
`define WDT_ST_HALF_LAT 1
`define WDT_ST_TERM_LAT 0

// Control bits.
`define WDT_CT_PER_HI 14
`define WDT_CT_PER_LO 8
`define WDT_CT_PROTECT_N 6
`define WDT_CT_CPU_RST_EN 5
`define WDT_CT_TERM_IRQ_EN 4
`define WDT_CT_HALF_IRQ_EN 3
`define WDT_CT_HALF_CMP_EN 2
`define WDT_CT_TERM_CMP_EN 1
`define WDT_CT_CNT_CLEAR 0

// Reset values.
`define WDT_PERIOD_RST 7'h7F
`define WDT_MASK_RST 2'h3

// One period step is 10 ms; the counter runs in half steps of 5 ms.
`define WDT_STEP_MS 10
`define WDT_CLK_KHZ 125000
`define WDT_HALF_STEP_CYC (`WDT_STEP_MS * `WDT_CLK_KHZ / 2)
`define WDT_PRE_W 20
`define WDT_CNT_W 9

// AXI responses.
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

//--- core/wdt_top.v
// Purpose: Watchdog with half-count wake and full-count reset events.
// Assumes: Synchronous active-low reset acts as power-on reset.
// Notes: Registers are reached over AXI4-Lite, one access at a time.
`timescale 1ns/100ps
`include "wdt_defines.vh"

module wdt_top #(
  parameter [`WDT_PRE_W-1:0] HALF_STEP_CYC = `WDT_HALF_STEP_CYC
) (
  input wire aclk, // System clock.
  input wire aresetn, // Synchronous reset, active low.
  input wire [`WDT_ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire [2:0] s_axi_awprot, // Write protection type.
  input wire s_axi_awvalid, // Write address valid.
  output reg s_axi_awready, // Write address ready.
  input wire [31:0] s_axi_wdata, // Write data.
  input wire [3:0] s_axi_wstrb, // Write byte strobes.
  input wire s_axi_wvalid, // Write data valid.
  output reg s_axi_wready, // Write data ready.
  output reg [1:0] s_axi_bresp, // Write response.
  output reg s_axi_bvalid, // Write response valid.
  input wire s_axi_bready, // Write response ready.
  input wire [`WDT_ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire [2:0] s_axi_arprot, // Read protection type.
  input wire s_axi_arvalid, // Read address valid.
  output reg s_axi_arready, // Read address ready.
  output reg [31:0] s_axi_rdata, // Read data.
  output reg [1:0] s_axi_rresp, // Read response.
  output reg s_axi_rvalid, // Read data valid.
  input wire s_axi_rready, // Read data ready.
  output reg half_count_irq_q, // Wake event interrupt.
  output reg terminal_irq_q, // Terminal event interrupt.
  output reg irq_q, // Combined masked interrupt.
  output reg core_reset_q // Processor reset request.
);

  // Control register fields.
  reg [6:0] timeout_period_q;
  reg protect_n_q;
  reg cpu_reset_enable_q;
  reg terminal_irq_enable_q;
  reg half_count_irq_enable_q;
  reg half_count_compare_enable_q;
  reg terminal_compare_enable_q;
  reg counter_clear_q;
  reg [1:0] irq_mask_q;

  // Counters and status.
  reg [`WDT_PRE_W-1:0] pre_q;
  reg [`WDT_CNT_W-1:0] cnt_q;
  reg half_count_raw_q;
  reg terminal_count_raw_q;
  reg half_count_latched_q;
  reg terminal_count_latched_q;

  // Write channel capture.
  reg aw_have_q;
  reg w_have_q;
  reg [`WDT_ADDR_W-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire [`WDT_CNT_W-1:0] half_pt;
  wire [`WDT_CNT_W-1:0] term_pt;
  wire run;
  wire half_step;
  wire half_d;
  wire term_d;
  wire aw_hs;
  wire w_hs;
  wire wr_go;
  wire ar_hs;
  wire rd_status;
  wire [`WDT_ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;

  // Terminal count in 5 ms half steps; the wake point is half of it.
  assign half_pt = {1'b0, timeout_period_q} + 9'h001;
  assign term_pt = {half_pt[`WDT_CNT_W-2:0], 1'b0};

  // Counting needs a comparator enabled and no pending clear.
  assign run = (half_count_compare_enable_q | terminal_compare_enable_q) &
               ~counter_clear_q;
  assign half_step = run & (pre_q == HALF_STEP_CYC - 1'b1);

  assign half_d = half_count_compare_enable_q & (cnt_q >= half_pt);
  assign term_d = terminal_compare_enable_q & (cnt_q >= term_pt);

  // A write may take address and data in the same cycle as they arrive.
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign wr_addr = aw_have_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data = w_have_q ? w_data_q : s_axi_wdata;
  assign wr_strb = w_have_q ? w_strb_q : s_axi_wstrb;
  assign wr_go = (aw_have_q | aw_hs) & (w_have_q | w_hs) & ~s_axi_bvalid;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign rd_status = ar_hs & (s_axi_araddr == `WDT_STATUS_ADDR);

  // Only aligned full-address hits are mapped.
  function hit;
    input [`WDT_ADDR_W-1:0] a;
    begin
      hit = (a == `WDT_STATUS_ADDR) | (a == `WDT_CONTROL_ADDR) |
            (a == `WDT_MASK_ADDR);
    end
  endfunction

  // Write address and data are accepted in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WDT_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= hit(wr_addr) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
      end else begin
        if (aw_hs) begin
          aw_have_q <= 1'b1;
        end
        if (w_hs) begin
          w_have_q <= 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
      // Ready drops after each handshake until the response is gone.
      s_axi_awready <= ~(aw_have_q | aw_hs) | wr_go;
      s_axi_wready <= ~(w_have_q | w_hs) | wr_go;
      if (aw_hs || (aw_have_q && !wr_go)) begin
        s_axi_awready <= 1'b0;
      end
      if (w_hs || (w_have_q && !wr_go)) begin
        s_axi_wready <= 1'b0;
      end
      if (wr_go || s_axi_bvalid) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control register and mask.
  always @(posedge aclk) begin
    if (!aresetn) begin
      timeout_period_q <= `WDT_PERIOD_RST;
      protect_n_q <= 1'b1;
      cpu_reset_enable_q <= 1'b0;
      terminal_irq_enable_q <= 1'b0;
      half_count_irq_enable_q <= 1'b0;
      half_count_compare_enable_q <= 1'b0;
      terminal_compare_enable_q <= 1'b0;
      counter_clear_q <= 1'b1;
      irq_mask_q <= `WDT_MASK_RST;
    end else begin
      // The clear holds the counters until counting may resume.
      if (counter_clear_q &&
          (half_count_compare_enable_q || terminal_compare_enable_q)) begin
        counter_clear_q <= 1'b0;
      end
      if (wr_go && wr_addr == `WDT_CONTROL_ADDR) begin
        if (wr_strb[1]) begin
          timeout_period_q <= wr_data[`WDT_CT_PER_HI:`WDT_CT_PER_LO];
        end
        if (wr_strb[0]) begin
          terminal_irq_enable_q <= wr_data[`WDT_CT_TERM_IRQ_EN];
          half_count_irq_enable_q <= wr_data[`WDT_CT_HALF_IRQ_EN];
          if (wr_data[`WDT_CT_CNT_CLEAR]) begin
            counter_clear_q <= 1'b1;
          end
          if (protect_n_q) begin
            cpu_reset_enable_q <= wr_data[`WDT_CT_CPU_RST_EN];
            half_count_compare_enable_q <=
              wr_data[`WDT_CT_HALF_CMP_EN];
            terminal_compare_enable_q <=
              wr_data[`WDT_CT_TERM_CMP_EN];
          end
          // Once low, protect only returns high through reset.
          if (!wr_data[`WDT_CT_PROTECT_N]) begin
            protect_n_q <= 1'b0;
            cpu_reset_enable_q <= 1'b1;
            half_count_compare_enable_q <= 1'b1;
            terminal_compare_enable_q <= 1'b1;
          end
        end
      end
      // The mask gates only the combined line; each event line ignores it,
      // so software can poll one event while the shared line stays quiet.
      if (wr_go && wr_addr == `WDT_MASK_ADDR && wr_strb[0]) begin
        irq_mask_q <= wr_data[`WDT_ST_HALF_LAT:`WDT_ST_TERM_LAT];
      end
    end
  end

  // Prescaler and half-step counter; the count holds at the terminal.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= {`WDT_PRE_W{1'b0}};
      cnt_q <= {`WDT_CNT_W{1'b0}};
    end else if (!run) begin
      pre_q <= {`WDT_PRE_W{1'b0}};
      if (counter_clear_q) begin
        cnt_q <= {`WDT_CNT_W{1'b0}};
      end
    end else if (half_step) begin
      pre_q <= {`WDT_PRE_W{1'b0}};
      // Saturating keeps the raw terminal bit and the core reset steady.
      if (cnt_q < term_pt) begin
        cnt_q <= cnt_q + 9'h001;
      end
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // Raw and latched status; a new event wins over the read clear.
  always @(posedge aclk) begin
    if (!aresetn) begin
      half_count_raw_q <= 1'b0;
      terminal_count_raw_q <= 1'b0;
      half_count_latched_q <= 1'b0;
      terminal_count_latched_q <= 1'b0;
    end else begin
      half_count_raw_q <= half_d;
      terminal_count_raw_q <= term_d;
      if (half_d && !half_count_raw_q) begin
        half_count_latched_q <= 1'b1;
      end else if (rd_status) begin
        half_count_latched_q <= 1'b0;
      end
      if (term_d && !terminal_count_raw_q) begin
        terminal_count_latched_q <= 1'b1;
      end else if (rd_status) begin
        terminal_count_latched_q <= 1'b0;
      end
    end
  end

  // Interrupt and processor reset outputs.
  always @(posedge aclk) begin
    if (!aresetn) begin
      half_count_irq_q <= 1'b0;
      terminal_irq_q <= 1'b0;
      irq_q <= 1'b0;
      core_reset_q <= 1'b0;
    end else begin
      half_count_irq_q <= half_count_latched_q &
                          half_count_irq_enable_q;
      terminal_irq_q <= terminal_count_latched_q &
                        terminal_irq_enable_q;
      irq_q <= (half_count_latched_q & half_count_irq_enable_q &
                irq_mask_q[`WDT_ST_HALF_LAT]) |
               (terminal_count_latched_q & terminal_irq_enable_q &
                irq_mask_q[`WDT_ST_TERM_LAT]);
      // Software that fails to clear in time gets this reset.
      core_reset_q <= terminal_count_raw_q & cpu_reset_enable_q;
    end
  end

  // Read channel; one read outstanding, data registered on acceptance.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `WDT_RESP_OKAY;
    end else begin
      if (ar_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `WDT_RESP_OKAY;
        s_axi_rdata <= 32'h00000000;
        case (s_axi_araddr)
          `WDT_STATUS_ADDR: begin
            s_axi_rdata[3:0] <= {half_count_raw_q, terminal_count_raw_q,
                                 half_count_latched_q,
                                 terminal_count_latched_q};
          end
          `WDT_CONTROL_ADDR: begin
            s_axi_rdata[15:0] <= {1'b0, timeout_period_q, 1'b0,
                                  protect_n_q, cpu_reset_enable_q,
                                  terminal_irq_enable_q,
                                  half_count_irq_enable_q,
                                  half_count_compare_enable_q,
                                  terminal_compare_enable_q,
                                  counter_clear_q};
          end
          `WDT_MASK_ADDR: begin
            s_axi_rdata[1:0] <= irq_mask_q;
          end
          // Unmapped reads return zero so software never sees stale data.
          default: begin
            s_axi_rresp <= `WDT_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

//--- verification/wdt_sva.sv
// Purpose: Port-level checks for the watchdog timer.
// Assumes: Bound to the top module; one register access at a time.
// Notes: The register being read is tracked from the read address.
`timescale 1ns/100ps
`include "wdt_defines.vh"
module wdt_sva (
  input wire aclk, // Clock.
  input wire aresetn, // Reset, active low.
  input wire s_axi_awvalid, // Write address valid.
  input wire s_axi_awready, // Write address ready.
  input wire s_axi_wvalid, // Write data valid.
  input wire s_axi_wready, // Write data ready.
  input wire s_axi_bvalid, // Write response valid.
  input wire [31:0] s_axi_araddr, // Read address.
  input wire s_axi_arvalid, // Read address valid.
  input wire s_axi_arready, // Read address ready.
  input wire s_axi_rvalid, // Read data valid.
  input wire [31:0] s_axi_rdata, // Read data.
  input wire half_count_irq_q, // Wake interrupt.
  input wire terminal_irq_q, // Terminal interrupt.
  input wire irq_q, // Combined interrupt.
  input wire core_reset_q // Core reset.
);
  reg [31:0] ra_q;
  reg lock_q;
  wire st_rd = s_axi_rvalid && ra_q == `WDT_STATUS_ADDR;
  wire ct_rd = s_axi_rvalid && ra_q == `WDT_CONTROL_ADDR;
  // The lock is learnt from a read, so only later reads are judged.
  always @(posedge aclk) begin
    if (!aresetn)
      lock_q <= 1'b0;
    else if (ct_rd && !s_axi_rdata[6])
      lock_q <= 1'b1;
    if (s_axi_arvalid && s_axi_arready)
      ra_q <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read response late");
  property p_irq_or;
    irq_q |-> half_count_irq_q || terminal_irq_q;
  endproperty
  a_irq_or: assert property (p_irq_or)
    else $error("combined interrupt without source");
  property p_core;
    st_rd && core_reset_q |-> s_axi_rdata[2];
  endproperty
  a_core: assert property (p_core)
    else $error("core reset without terminal count");
  property p_lock;
    ct_rd && lock_q |-> s_axi_rdata[6:5] == 2'h1 && &s_axi_rdata[2:1];
  endproperty
  a_lock: assert property (p_lock)
    else $error("protected enables not held");
  property p_ctl_rsv;
    ct_rd |-> s_axi_rdata[31:15] == 17'h0 && !s_axi_rdata[7];
  endproperty
  a_ctl_rsv: assert property (p_ctl_rsv)
    else $error("control unused bits set");
  property p_st_rsv;
    st_rd |-> s_axi_rdata[31:4] == 28'h0;
  endproperty
  a_st_rsv: assert property (p_st_rsv)
    else $error("status unused bits set");
  property p_rst_out;
    $rose(aresetn) |-> !irq_q && !core_reset_q && !s_axi_rvalid;
  endproperty
  a_rst_out: assert property (p_rst_out)
    else $error("outputs active after reset");
endmodule

//--- verification/wdt_cpu_model.sv
// Purpose: Processor side of the reset and interrupt lines.
// Assumes: Both lines are levels synchronous to aclk.
// Notes: Rising edges are counted so each event is seen once.
`timescale 1ns/100ps
module wdt_cpu_model (
  input wire aclk, // Clock.
  input wire core_reset_q, // Reset request.
  input wire irq_q, // Interrupt.
  output int resets, // Core resets seen.
  output int irqs // Interrupts seen.
);
  reg rst_q = 1'b0;
  reg irq_seen_q = 1'b0;
  int rst_cnt = 0;
  int irq_cnt = 0;
  assign resets = rst_cnt;
  assign irqs = irq_cnt;
  always @(posedge aclk) begin
    rst_q <= core_reset_q;
    irq_seen_q <= irq_q;
    if (core_reset_q && !rst_q)
      rst_cnt <= rst_cnt + 1;
    if (irq_q && !irq_seen_q)
      irq_cnt <= irq_cnt + 1;
  end
endmodule

//--- verification/wdt_top_test.sv
// Purpose: Self-checking bench for the watchdog timer.
// Assumes: A short time base, so one period unit is eight clocks.
// Notes: The response ready signals stay high throughout.
`timescale 1ns/100ps
`include "wdt_defines.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module wdt_top_test;
  localparam logic [31:0] ST = `WDT_STATUS_ADDR;
  localparam logic [31:0] CT = `WDT_CONTROL_ADDR;
  localparam logic [31:0] MK = `WDT_MASK_ADDR;
  logic aclk = '0;
  logic aresetn = '0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
  logic s_axi_bready = '1, s_axi_rready = '1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, lock_m;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, ctl_m;
  logic half_count_irq_q, terminal_irq_q, irq_q, core_reset_q;
  int error_cnt = 0, checked = 0, cyc = 0, resets, irqs, p;
  wdt_top #(.HALF_STEP_CYC(20'h4)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .half_count_irq_q(half_count_irq_q), .terminal_irq_q(terminal_irq_q),
    .irq_q(irq_q), .core_reset_q(core_reset_q));
  wdt_cpu_model u_cpu (
    .aclk(aclk), .core_reset_q(core_reset_q), .irq_q(irq_q),
    .resets(resets), .irqs(irqs));
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= '0;
      if (s_axi_wready) s_axi_wvalid <= '0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= '0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Expected control value: a protect write locks three enables on.
  // Disabled byte lanes keep their old value; the clear bit only sets.
  function automatic void m_wr(input logic [31:0] d);
    logic clr;
    if (!s_axi_wstrb[1]) d[14:8] = ctl_m[14:8];
    if (!s_axi_wstrb[0]) d[7:0] = ctl_m[7:0];
    clr = ctl_m[0] | d[0];
    if (lock_m || !d[6]) begin
      lock_m = '1;
      ctl_m = (d & 32'h7F18) | 32'h26;
    end else
      ctl_m = d & 32'h7F7E;
    ctl_m[0] = clr & ~|ctl_m[2:1];
  endfunction
  task automatic rd_chk(input logic [31:0] a, e,
                        input logic [1:0] er = `WDT_RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask
  task automatic wr_chk(input logic [31:0] a, d,
                        input logic [1:0] er = `WDT_RESP_OKAY);
    logic [1:0] r;
    wr(a, d, r);
    `CHK(r, er)
    if (a == CT) m_wr(d);
  endtask
  task automatic reset_dut;
    aresetn <= '0;
    repeat (20) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    ctl_m = 32'h7F41;
    lock_m = '0;
  endtask
  initial begin
    void'($urandom(32'h8D5F));
    reset_dut;
    rd_chk(CT, ctl_m);
    rd_chk(ST, 32'h0);
    rd_chk(MK, 32'h3);
    rd_chk(32'h0, 32'h0, `WDT_RESP_SLVERR);
    wr_chk(32'hFFF7FDA0, 32'h0, `WDT_RESP_SLVERR);
    $display("test reset values done");
    p = $urandom % 4;
    wr_chk(CT, 32'h7E | p << 8);
    repeat (16 * p + 20) @(posedge aclk);
    `CHK(half_count_irq_q, 1'b1)
    `CHK(terminal_irq_q, 1'b1)
    `CHK(core_reset_q, 1'b1)
    wr_chk(MK, 32'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq_q, 1'b0)
    wr_chk(MK, 32'h3);
    repeat (2) @(posedge aclk);
    `CHK(irqs, 2)
    rd_chk(ST, 32'hF);
    rd_chk(ST, 32'hC);
    repeat (2) @(posedge aclk);
    `CHK(irq_q, 1'b0)
    `CHK(half_count_irq_q, 1'b0)
    `CHK(terminal_irq_q, 1'b0)
    `CHK(resets, 1)
    $display("test events done");
    wr_chk(CT, 32'h41);
    repeat (2) @(posedge aclk);
    rd_chk(ST, 32'h0);
    rd_chk(CT, ctl_m);
    `CHK(core_reset_q, 1'b0)
    s_axi_wstrb <= 4'h2;
    wr_chk(CT, 32'h7F00);
    s_axi_wstrb <= 4'hF;
    rd_chk(CT, ctl_m);
    wr_chk(CT, 32'h7F47);
    rd_chk(CT, ctl_m);
    rd_chk(ST, 32'h0);
    $display("test counter clear done");
    wr_chk(CT, 32'h7F00);
    rd_chk(CT, ctl_m);
    wr_chk(CT, 32'h7F58);
    rd_chk(CT, ctl_m);
    reset_dut;
    rd_chk(CT, ctl_m);
    $display("test protect done");
    print_verdict;
  end
endmodule
bind wdt_top wdt_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .half_count_irq_q(half_count_irq_q),
  .terminal_irq_q(terminal_irq_q), .irq_q(irq_q),
  .core_reset_q(core_reset_q));
